// ### energy_accum_pkg.sv
// Constants shared by the apparent energy accumulator block.
// Assumes a 20 MHz APB clock; register indices are word indices on APB.
package energy_accum_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_FREQ_KHZ  = 20000;  // 20 MHz bus clock
  localparam int ACC_RATE_KHZ  = 1024;   // 1.024 MHz accumulation rate
  localparam int SAMPLE_KHZ    = 8;      // Power values arrive at 8 kHz
  localparam int RATE_W        = 16;
  localparam logic [RATE_W-1:0] RATE_STEP = RATE_W'(ACC_RATE_KHZ);
  localparam logic [RATE_W-1:0] RATE_WRAP = RATE_W'(CLK_FREQ_KHZ);

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [15:0] IDX_PHASE_A_ENERGY = 16'he40c;
  localparam logic [15:0] IDX_PHASE_B_ENERGY = 16'he40d;
  localparam logic [15:0] IDX_PHASE_C_ENERGY = 16'he40e;
  localparam logic [15:0] IDX_EVENT_FLAGS    = 16'he502;
  localparam logic [15:0] IDX_EVENT_ENABLES  = 16'he50a;
  localparam logic [15:0] IDX_NOMINAL_VOLT   = 16'he533;
  localparam logic [15:0] IDX_COMPUTATION    = 16'he60e;
  localparam logic [15:0] IDX_ACCUMULATION   = 16'he701;
  localparam logic [15:0] IDX_LINE_CYCLE     = 16'he702;
  localparam logic [15:0] IDX_THRESHOLD      = 16'hea04;
  localparam int          ADDR_W             = 18;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int HALF_FULL_BIT    = 4;   // Flag and enable position
  localparam int CLEAR_ON_READ_BIT = 6;  // In line cycle config
  localparam int WIRING_LSB       = 4;   // Wiring select [5:4]
  localparam int NOMINAL_EN_LSB   = 11;  // Nominal enables [13:11]
  localparam int HALF_FULL_POS    = 30;  // Energy bit watched
  localparam int THRESH_ZEROS     = 27;  // Zero bits under threshold
  localparam logic [7:0]  THRESHOLD_RESET = 8'h03;
  localparam logic [15:0] COMPUTATION_RESET = 16'h0000;
  localparam logic [31:0] ENERGY_MOST_NEG  = 32'h8000_0000;

  // Wiring codes
  localparam logic [1:0] WIRING_FOUR_WIRE  = 2'b00;
  localparam logic [1:0] WIRING_THREE_WIRE = 2'b01;
  localparam logic [1:0] WIRING_RESERVED   = 2'b10;
  localparam logic [1:0] WIRING_NEG_A      = 2'b11;

endpackage

// ### apparent_energy_accumulator.sv
// Three-phase apparent energy integrator with an APB register slave.
// Assumes rms inputs and their strobe come from logic on pclk.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module apparent_energy_accumulator #(
  parameter int RMS_W = 24
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [energy_accum_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sample_strobe,
  input  wire logic [RMS_W-1:0]          phase_a_voltage_rms,
  input  wire logic [RMS_W-1:0]          line_ac_voltage_rms,
  input  wire logic [RMS_W-1:0]          phase_c_voltage_rms,
  input  wire logic [RMS_W-1:0]          phase_a_current_rms,
  input  wire logic [RMS_W-1:0]          phase_b_current_rms,
  input  wire logic [RMS_W-1:0]          phase_c_current_rms,
  input  wire logic [RMS_W-1:0]          measured_b_voltage_rms,
  output logic      [RMS_W-1:0]          phase_b_voltage_rms,
  output logic      [2:0]                energy_pulse,
  output logic                           interrupt_line_zero_n
);

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // The 28-bit power is cut from the top of the product, so it needs 14 bits
  if (RMS_W < 14 || RMS_W > 32)
  begin : g_bad_width
    $error("RMS_W must lie between 14 and 32");
  end

  localparam int PWR_W = 28;            // Instantaneous power width
  localparam int ACC_W = 37;            // First stage headroom
  localparam int PROD_W = 2 * RMS_W;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [7:0]             energy_threshold_byte_q;
  logic [15:0]            computation_config_q;
  logic [1:0]             wiring_select_q;
  logic                   clear_on_read_q;
  logic                   energy_half_full_flag_q;
  logic                   event_enables_zero_q;
  logic [RMS_W-1:0]       nominal_voltage_value_q;
  logic [energy_accum_pkg::RATE_W-1:0] rate_q;
  logic                   acc_tick_q;
  logic [PWR_W-1:0]       power_q   [3];
  logic [ACC_W-1:0]       stage1_q  [3];
  logic [31:0]            count_q   [3];
  logic [31:0]            phase_energy_accum_q [3];
  logic [2:0]             pulse_d;
  logic [2:0]             half_full_hit;
  logic [ACC_W-1:0]       threshold;
  logic [15:0]            index;
  logic                   wait_cycle;
  logic                   done;
  logic [2:0]             read_sel;
  logic                   rate_wrap;

  // Scaled product of an rms voltage and an rms current
  function automatic logic [PWR_W-1:0] power_of(
    input logic [RMS_W-1:0] volt,
    input logic [RMS_W-1:0] curr
  );
    logic [PROD_W-1:0] prod;
    prod = volt * curr;
    power_of = prod[PROD_W-1 -: PWR_W];
  endfunction

  // Measured voltage, or the nominal value where that phase enables it
  function automatic logic [RMS_W-1:0] pick_volt(input int p, input logic [RMS_W-1:0] v);
    pick_volt = computation_config_q[energy_accum_pkg::NOMINAL_EN_LSB + p]
                ? nominal_voltage_value_q : v;
  endfunction

  // Which phase energy register an index names, one-hot
  function automatic logic [2:0] energy_sel(input logic [15:0] idx);
    energy_sel = {idx == energy_accum_pkg::IDX_PHASE_C_ENERGY,
                  idx == energy_accum_pkg::IDX_PHASE_B_ENERGY,
                  idx == energy_accum_pkg::IDX_PHASE_A_ENERGY};
  endfunction

  // ==========================================================
  // Bus decode and accumulation rate
  // ==========================================================
  // Wait state first, completion edge second; side effects only at done
  assign index      = paddr[17:2];
  assign wait_cycle = psel & penable & ~pready;
  assign done       = psel & penable & pready;
  assign read_sel   = energy_sel(index) & {3{~pwrite & (paddr[1:0] == 2'b00)}};
  assign rate_wrap  = rate_q + energy_accum_pkg::RATE_STEP >= energy_accum_pkg::RATE_WRAP;
  // Threshold byte sits above 27 zero bits
  assign threshold  = {2'b00, energy_threshold_byte_q,
                       {energy_accum_pkg::THRESH_ZEROS{1'b0}}};

  // Fractional divider: 20 MHz is no whole multiple of 1.024 MHz,
  // so ticks jitter by one clock but average exactly right.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_q     <= '0;
      acc_tick_q <= 1'b0;
    end
    else
    begin
      rate_q     <= rate_q + energy_accum_pkg::RATE_STEP
                    - (rate_wrap ? energy_accum_pkg::RATE_WRAP : '0);
      acc_tick_q <= rate_wrap;
    end
  end

  // ==========================================================
  // Power inputs per wiring mode
  // ==========================================================
  // Latched at the 8 kHz strobe, held between strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < 3; p++)
        power_q[p] <= '0;
      phase_b_voltage_rms <= '0;
    end
    else if (sample_strobe)
    begin
      // Phases A and C take their measured voltage or the nominal value
      power_q[0] <= power_of(pick_volt(0, phase_a_voltage_rms), phase_a_current_rms);
      power_q[2] <= power_of(pick_volt(2, phase_c_voltage_rms), phase_c_current_rms);
      case (wiring_select_q)
        energy_accum_pkg::WIRING_THREE_WIRE:
        begin
          phase_b_voltage_rms <= line_ac_voltage_rms;
          power_q[1]          <= '0;
        end
        energy_accum_pkg::WIRING_NEG_A:
        begin
          // The rms of minus A equals the rms of A
          phase_b_voltage_rms <= phase_a_voltage_rms;
          power_q[1] <= power_of(pick_volt(1, phase_a_voltage_rms), phase_b_current_rms);
        end
        default:
        begin
          // Reserved code 10 behaves as four-wire
          phase_b_voltage_rms <= measured_b_voltage_rms;
          power_q[1] <= power_of(pick_volt(1, measured_b_voltage_rms), phase_b_current_rms);
        end
      endcase
    end
  end

  // ==========================================================
  // First stage: power into threshold accumulator
  // ==========================================================
  // One pulse per tick at most; the remainder carries any excess.
  // Half full when a pulse carries bit 30 from clear to set.
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      pulse_d[p] = acc_tick_q
                   & (stage1_q[p] + ACC_W'(power_q[p]) >= threshold);
      half_full_hit[p] = pulse_d[p] & ~count_q[p][energy_accum_pkg::HALF_FULL_POS]
                         & (&count_q[p][energy_accum_pkg::HALF_FULL_POS-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < 3; p++)
        stage1_q[p] <= '0;
      energy_pulse <= '0;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
        if (pulse_d[p])
          stage1_q[p] <= stage1_q[p] + ACC_W'(power_q[p]) - threshold;
        else if (acc_tick_q)
          stage1_q[p] <= stage1_q[p] + ACC_W'(power_q[p]);
      energy_pulse <= pulse_d;
    end
  end

  // ==========================================================
  // Second stage: pulse counters
  // ==========================================================
  // Clear-on-read subtracts the snapshot instead of zeroing, so a
  // pulse between snapshot and completion stays in the counter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < 3; p++)
        count_q[p] <= '0;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
        count_q[p] <= count_q[p]
                      - ((done && read_sel[p] && clear_on_read_q)
                         ? phase_energy_accum_q[p] : 32'h0000_0000)
                      + {31'h0000_0000, pulse_d[p]};
    end
  end

  // Snapshot taken in the wait state, at the same edge that loads prdata from count_q
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int p = 0; p < 3; p++)
        phase_energy_accum_q[p] <= '0;
    end
    else
    begin
      for (int p = 0; p < 3; p++)
        if (wait_cycle && read_sel[p])
          phase_energy_accum_q[p] <= count_q[p];
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      energy_threshold_byte_q <= energy_accum_pkg::THRESHOLD_RESET;
      computation_config_q    <= energy_accum_pkg::COMPUTATION_RESET;
      wiring_select_q         <= energy_accum_pkg::WIRING_FOUR_WIRE;
      clear_on_read_q         <= 1'b0;
      event_enables_zero_q    <= 1'b0;
      nominal_voltage_value_q <= '0;
    end
    else if (done && pwrite)
    begin
      // A zero threshold is software's fault and is stored as written
      if (index == energy_accum_pkg::IDX_THRESHOLD)
        energy_threshold_byte_q <= pwdata[7:0];
      else if (index == energy_accum_pkg::IDX_COMPUTATION)
        computation_config_q <= pwdata[15:0];
      else if (index == energy_accum_pkg::IDX_ACCUMULATION)
        wiring_select_q <= pwdata[energy_accum_pkg::WIRING_LSB +: 2];
      else if (index == energy_accum_pkg::IDX_LINE_CYCLE)
        clear_on_read_q <= pwdata[energy_accum_pkg::CLEAR_ON_READ_BIT];
      else if (index == energy_accum_pkg::IDX_EVENT_ENABLES)
        event_enables_zero_q <= pwdata[energy_accum_pkg::HALF_FULL_BIT];
      else if (index == energy_accum_pkg::IDX_NOMINAL_VOLT)
        nominal_voltage_value_q <= pwdata[RMS_W-1:0];
    end
  end

  // ==========================================================
  // Half-full flag and interrupt
  // ==========================================================
  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      energy_half_full_flag_q <= 1'b0;
    else if (|half_full_hit)
      energy_half_full_flag_q <= 1'b1;
    else if (done && pwrite && index == energy_accum_pkg::IDX_EVENT_FLAGS
             && pwdata[energy_accum_pkg::HALF_FULL_BIT])
      energy_half_full_flag_q <= 1'b0;
  end

  // Line follows the masked flag one clock later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_line_zero_n <= 1'b1;
    else
      interrupt_line_zero_n <= ~(energy_half_full_flag_q
                                 & event_enables_zero_q);
  end

  // ==========================================================
  // APB answer
  // ==========================================================
  // One wait state on every access, then ready for one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (wait_cycle)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (paddr[1:0] != 2'b00 || (pwrite && energy_sel(index) != 3'b000))
        pslverr <= 1'b1;  // Misaligned, or a write to a read-only energy register
      else if (pwrite)
        prdata <= '0;  // Writes answer with zero data
      else if (index == energy_accum_pkg::IDX_PHASE_A_ENERGY)
        prdata <= count_q[0];
      else if (index == energy_accum_pkg::IDX_PHASE_B_ENERGY)
        prdata <= count_q[1];
      else if (index == energy_accum_pkg::IDX_PHASE_C_ENERGY)
        prdata <= count_q[2];
      else if (index == energy_accum_pkg::IDX_THRESHOLD)
        prdata <= {24'h00_0000, energy_threshold_byte_q};
      else if (index == energy_accum_pkg::IDX_COMPUTATION)
        prdata <= {16'h0000, computation_config_q};
      else if (index == energy_accum_pkg::IDX_ACCUMULATION)
        prdata <= {26'h000_0000, wiring_select_q, 4'h0};
      else if (index == energy_accum_pkg::IDX_LINE_CYCLE)
        prdata <= {25'h000_0000, clear_on_read_q, 6'h00};
      else if (index == energy_accum_pkg::IDX_EVENT_FLAGS)
        prdata <= {27'h000_0000, energy_half_full_flag_q, 4'h0};
      else if (index == energy_accum_pkg::IDX_EVENT_ENABLES)
        prdata <= {27'h000_0000, event_enables_zero_q, 4'h0};
      else if (index == energy_accum_pkg::IDX_NOMINAL_VOLT)
        prdata <= 32'(nominal_voltage_value_q);
      else
        pslverr <= 1'b1;  // Unmapped address
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ### energy_accum_monitor.sv
// Concurrent checks on the APB slave, pulse and interrupt ports.
// Assumes one pclk domain; bound to the top module below.
`timescale 1ns/1ps

module energy_accum_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  energy_pulse,
  input wire logic        interrupt_line_zero_n
);
  // ==========================================================
  // Decodes
  // ==========================================================
  logic clr_now;
  logic e_addr;
  logic mask_off;
  // Interrupt enable cleared by a write completing this cycle
  assign mask_off = psel && penable && pready && pwrite && !pwdata[4]
                    && paddr == {energy_accum_pkg::IDX_EVENT_ENABLES, 2'b00};
  // Flag clear write completing this cycle
  assign clr_now = psel && penable && pready && pwrite && pwdata[4]
                   && paddr == {energy_accum_pkg::IDX_EVENT_FLAGS, 2'b00};
  assign e_addr = paddr[17:2] >= energy_accum_pkg::IDX_PHASE_A_ENERGY
                  && paddr[17:2] <= energy_accum_pkg::IDX_PHASE_C_ENERGY;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Access steps: one wait edge, then the answer
  // ==========================================================
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_access;
    s_wait ##1 (psel && penable && pready);
  endsequence

  AST_WAIT_THEN_READY: assert property (s_wait |=> pready)
    else $error("access not answered one cycle after wait");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_HAS_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without an access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error outside an answer");
  AST_ENERGY_WRITE_REFUSED: assert property (s_access ##0 (pwrite && e_addr) |-> pslverr)
    else $error("energy write accepted");
  AST_MISALIGNED_REFUSED: assert property (s_access ##0 (paddr[1:0] != 2'b00) |-> pslverr)
    else $error("misaligned access accepted");
  // Ticks are 19 or more clocks apart, so a pulse is followed by quiet
  AST_PULSE_SPACED: assert property (energy_pulse != 3'b000 |=> (energy_pulse == 3'b000) [*8])
    else $error("energy pulses too close");
  AST_IRQ_RELEASE: assert property (clr_now |=> ##1 interrupt_line_zero_n)
    else $error("interrupt not released after clear");
  AST_IRQ_CAUSE: assert property ($rose(interrupt_line_zero_n) |-> $past(clr_now || mask_off, 2))
    else $error("interrupt released without clear");
endmodule

bind apparent_energy_accumulator energy_accum_checker chk_i (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .pready                (pready),
  .pslverr               (pslverr),
  .energy_pulse          (energy_pulse),
  .interrupt_line_zero_n (interrupt_line_zero_n)
);

// ### testbench.sv
// Self-checking bench for the apparent energy accumulator.
// Assumes RMS_W of 24 and pulse rates from a 20 MHz pclk.
`timescale 1ns/1ps

module testbench;
  typedef struct {logic w; logic [17:0] a; logic [31:0] d; logic e;} row_type;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        sample_strobe;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        irq_n;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] b0;
  logic [23:0] va, vl, vc, ia, ib, ic, vbm, vbo;
  logic [2:0]  pulse;
  logic [31:0] cnt [3] = '{0, 0, 0};
  int          fails;
  int          checks;
  row_type     rows [9];

  apparent_energy_accumulator #(.RMS_W(24)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_strobe(sample_strobe),
    .phase_a_voltage_rms(va), .line_ac_voltage_rms(vl),
    .phase_c_voltage_rms(vc), .phase_a_current_rms(ia),
    .phase_b_current_rms(ib), .phase_c_current_rms(ic),
    .measured_b_voltage_rms(vbm), .phase_b_voltage_rms(vbo),
    .energy_pulse(pulse), .interrupt_line_zero_n(irq_n)
  );

  // ==========================================================
  // Clock and pulse counting
  // ==========================================================
  always #25 pclk = ~pclk;

  // Bench count of pulses per phase since reset
  always @(posedge pclk)
    for (int p = 0; p < 3; p++)
      if (pulse[p] === 1'b1)
        cnt[p] <= cnt[p] + 1;

  // ==========================================================
  // Tasks
  // ==========================================================
  function automatic logic [17:0] ba(input logic [15:0] i);
    return {i, 2'b00};
  endfunction

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20)
    begin
      fails++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Latch the rms inputs; a pulse edge apart from any bus write
  task automatic strobe;
    sample_strobe <= 1'b1;
    @(posedge pclk);
    sample_strobe <= 1'b0;
    @(posedge pclk);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; sample_strobe = 0;
    va = 24'h80_0000; vl = 24'h12_3456; vc = 24'h80_0000; vbm = 24'h65_4321;
    ia = 0; ib = 0; ic = 0;
    rows = '{
      '{1'b0, ba(energy_accum_pkg::IDX_THRESHOLD), 32'h0000_0003, 1'b0},
      '{1'b0, ba(energy_accum_pkg::IDX_EVENT_ENABLES), 32'h0000_0000, 1'b0},
      '{1'b0, ba(energy_accum_pkg::IDX_ACCUMULATION), 32'h0000_0000, 1'b0},
      '{1'b1, ba(energy_accum_pkg::IDX_THRESHOLD), 32'hFFFF_FF01, 1'b0},
      '{1'b0, ba(energy_accum_pkg::IDX_THRESHOLD), 32'h0000_0001, 1'b0},
      '{1'b1, ba(energy_accum_pkg::IDX_PHASE_A_ENERGY), 32'h0000_0005, 1'b1},
      '{1'b0, ba(energy_accum_pkg::IDX_PHASE_A_ENERGY), 32'h0000_0000, 1'b0},
      '{1'b0, ba(energy_accum_pkg::IDX_THRESHOLD) + 18'h1, 32'h0000_0000, 1'b1},
      '{1'b0, 18'h0_0000, 32'h0000_0000, 1'b1}};
    repeat (10) @(posedge pclk);
    // Outputs held quiet while in reset
    chk({29'h0, pready, pslverr, irq_n}, 32'h0000_0001);
    chk({5'h0, pulse, vbo}, 32'h0000_0000);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    // Reset values, narrow fields, refused and unmapped places
    foreach (rows[k])
    begin
      apb(rows[k].w, rows[k].a, rows[k].w ? rows[k].d : 32'h0);
      if (!rows[k].w)
        chk(rd, rows[k].d);
      chk({31'h0, er}, {31'h0, rows[k].e});
    end
    // Every wiring code, phase B voltage source
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, ba(energy_accum_pkg::IDX_ACCUMULATION), 32'(c) << 4);
      strobe();
      repeat (2) @(posedge pclk);
      chk(32'(vbo), c == 1 ? 32'(vl) : c == 3 ? 32'(va) : 32'(vbm));
    end
    // Three-wire run: A at half the threshold, C at a quarter, B silent
    apb(1'b1, ba(energy_accum_pkg::IDX_ACCUMULATION), 32'h0000_0010);
    ia <= 24'h80_0000;
    ib <= 24'h80_0000;
    ic <= 24'h40_0000;
    strobe();
    repeat (20000) @(posedge pclk);
    ia <= 0;
    ib <= 0;
    ic <= 0;
    strobe();
    repeat (60) @(posedge pclk);
    chk(32'(cnt[0] >= 510 && cnt[0] <= 514), 32'h0000_0001);
    chk(32'(cnt[2] >= 254 && cnt[2] <= 258), 32'h0000_0001);
    chk(cnt[1], 32'h0000_0000);
    for (int p = 0; p < 3; p++)
    begin
      apb(1'b0, ba(energy_accum_pkg::IDX_PHASE_A_ENERGY + 16'(p)), 32'h0);
      chk(rd, cnt[p]);
    end
    // Clear on read: value once, then zero
    apb(1'b1, ba(energy_accum_pkg::IDX_LINE_CYCLE), 32'h0000_0040);
    apb(1'b0, ba(energy_accum_pkg::IDX_PHASE_C_ENERGY), 32'h0);
    chk(rd, cnt[2]);
    apb(1'b0, ba(energy_accum_pkg::IDX_PHASE_C_ENERGY), 32'h0);
    chk(rd, 32'h0000_0000);
    // Nominal voltage stands in for a zero measured phase A voltage
    apb(1'b1, ba(energy_accum_pkg::IDX_NOMINAL_VOLT), 32'h0080_0000);
    // Only phase A nominal enable; phase B and C nominal enables stay clear
    apb(1'b1, ba(energy_accum_pkg::IDX_COMPUTATION), 32'h0000_0800);
    va <= 0;
    ia <= 24'h80_0000;
    strobe();
    b0 = cnt[0];
    repeat (4000) @(posedge pclk);
    ia <= 0;
    strobe();
    repeat (60) @(posedge pclk);
    chk(32'(cnt[0] - b0 >= 100 && cnt[0] - b0 <= 105), 32'h0000_0001);
    // Enabled with no event the line stays released; acknowledge keeps the flag clear
    apb(1'b1, ba(energy_accum_pkg::IDX_EVENT_ENABLES), 32'h0000_0010);
    apb(1'b0, ba(energy_accum_pkg::IDX_EVENT_ENABLES), 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b1, ba(energy_accum_pkg::IDX_EVENT_FLAGS), 32'h0000_0010);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_n}, 32'h0000_0001);
    apb(1'b0, ba(energy_accum_pkg::IDX_EVENT_FLAGS), 32'h0);
    chk(rd & 32'h0000_0010, 32'h0000_0000);
    // Reset in mid-run restores the threshold and empties the counters
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({29'h0, pready, pslverr, irq_n}, 32'h0000_0001);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, ba(energy_accum_pkg::IDX_THRESHOLD), 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, ba(energy_accum_pkg::IDX_PHASE_A_ENERGY), 32'h0);
    chk(rd, 32'h0000_0000);
    complete_run();
  end
endmodule
